// ===== hw/led_flash_pkg.sv
// package: register map, fields, reset values and event timing
package led_flash_pkg;
    // =======================================================
    // register offsets
    localparam logic [7:0] input_voltage_monitor_config_config_offset = 8'h80;
    localparam logic [7:0] captured_flash_offset     = 8'h81;
    localparam logic [7:0] torch_current_offset      = 8'ha0;
    // =======================================================
    // field positions
    localparam int monitor_enable_bit       = 0;
    localparam int monitor_threshold_lsb    = 1;
    localparam int flash_monitor_enable_bit = 3;
    localparam int flash_threshold_lsb      = 4;
    localparam int torch_led1_lsb           = 0;
    localparam int torch_led2_lsb           = 3;
    localparam int captured_led1_lsb        = 0;
    localparam int captured_led2_lsb        = 4;
    // =======================================================
    // reset values
    localparam logic [7:0] input_voltage_monitor_config_config_reset = 8'h00;
    localparam logic [7:0] captured_flash_reset     = 8'h00;
    localparam logic [5:0] torch_current_reset      = 6'h00;
    // =======================================================
    // timing
    localparam int clock_mhz            = 25;
    localparam int slow_event_delay_us  = 250;
    localparam int flash_deglitch_us    = 8;
    localparam int slow_event_cycles    = slow_event_delay_us * clock_mhz;
    localparam int flash_deglitch_cycles = flash_deglitch_us * clock_mhz;
endpackage

// ===== hw/led_flash_monitor_registers.sv
// register bank and event capture for the led flash monitor
//
// Functional notes
// - bit 0 of the monitor config enables the input monitor, reset 0.
// - bits 2:1 and 5:4 select steady and flash thresholds 2.9 V..3.2 V.
// - the captured level is read-only and holds both 4-bit flash codes.
// - a thermal trip with thermal-sense mode selected causes a capture.
// - input below steady threshold with the monitor enabled captures.
// - input below flash threshold with bit 3 set captures; bit 3 resets 0.
// - the capture loads on the edge that ends the event flag pulse and reads back the cycle after.
// - thermal and steady events flag and capture 250 us after crossing.
// - the flash monitor deglitches 8 us and flags/captures after it.
// - torch bits 2:0 select the led1 torch current.
// - torch bits 5:3 select the led2 torch current; 7:6 are unused.
// - torch codes step 31.25 mA from 31.25 mA up to 250 mA.
// - captured codes use the 4-bit flash encoding, 62.5 mA per step.
`timescale 1ns/1ps
module led_flash_monitor_registers #(
    parameter int slow_cycles  = led_flash_pkg::slow_event_cycles,
    parameter int flash_cycles = led_flash_pkg::flash_deglitch_cycles
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_address,
    input  wire logic [7:0] reg_write_data,
    output logic      [7:0] reg_read_data,
    output logic            reg_address_valid,
    input  wire logic       thermal_sense_mode,
    input  wire logic [7:0] flash_current_code,
    input  wire logic       led1_active,
    input  wire logic       led2_active,
    input  wire logic       thermal_sense_below_trip,
    input  wire logic       input_below_monitor_threshold,
    input  wire logic       input_below_flash_threshold,
    output logic            monitor_enable,
    output logic      [1:0] input_monitor_threshold,
    output logic            flash_monitor_enable,
    output logic      [1:0] input_flash_threshold,
    output logic      [2:0] torch_led1_code,
    output logic      [2:0] torch_led2_code,
    output logic            thermal_flag_pulse,
    output logic            monitor_flag_pulse,
    output logic            flash_monitor_flag_pulse
);
    // =======================================================
    // elaboration checks
    // a limit of 1 would fire on the first qualifying cycle and
    // leave no deglitch at all
    generate
        if (slow_cycles < 2) begin : gen_bad_slow
            $error("slow_cycles must be at least 2");
        end
        if (flash_cycles < 2) begin : gen_bad_flash
            $error("flash_cycles must be at least 2");
        end
    endgenerate

    // =======================================================
    // address decode
    function automatic logic address_hit(input logic [7:0] address,
                                         input logic [7:0] offset);
        return address == offset;
    endfunction

    wire logic hit_config  = address_hit(reg_address,
        led_flash_pkg::input_voltage_monitor_config_config_offset);
    wire logic hit_capture = address_hit(reg_address,
        led_flash_pkg::captured_flash_offset);
    wire logic hit_torch   = address_hit(reg_address,
        led_flash_pkg::torch_current_offset);

    // the capture register has no write path at all
    wire logic write_config = reg_write & hit_config;
    wire logic write_torch  = reg_write & hit_torch;

    // =======================================================
    // registers
    logic [7:0] config_reg;
    logic [7:0] captured;
    logic [5:0] torch;

    // bits 7:6 are unused and always read back zero
    wire logic [7:0] next_config = {2'b00, reg_write_data[5:0]};
    wire logic [5:0] next_torch  = reg_write_data[5:0];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            config_reg <=
                led_flash_pkg::input_voltage_monitor_config_config_reset;
            torch      <= led_flash_pkg::torch_current_reset;
        end else begin
            if (write_config)
                config_reg <= next_config;
            if (write_torch)
                torch <= next_torch;
        end
    end

    // =======================================================
    // field outputs
    assign monitor_enable =
        config_reg[led_flash_pkg::monitor_enable_bit];
    assign input_monitor_threshold =
        config_reg[led_flash_pkg::monitor_threshold_lsb +: 2];
    assign flash_monitor_enable =
        config_reg[led_flash_pkg::flash_monitor_enable_bit];
    assign input_flash_threshold =
        config_reg[led_flash_pkg::flash_threshold_lsb +: 2];
    // code n means (n+1) * 31.25 mA in the analog driver
    assign torch_led1_code =
        torch[led_flash_pkg::torch_led1_lsb +: 3];
    assign torch_led2_code =
        torch[led_flash_pkg::torch_led2_lsb +: 3];

    // =======================================================
    // read path
    // reading has no side effect on any register
    wire logic [7:0] next_read_data =
        hit_config  ? config_reg :
        hit_capture ? captured :
        hit_torch   ? {2'b00, torch} : 8'h00;
    assign reg_read_data     = next_read_data;
    assign reg_address_valid = hit_config | hit_capture | hit_torch;

    // =======================================================
    // pin synchronisers
    // three stages, a change counts once stages 1 and 2 agree; only
    // stage 1 reads stage 0, the one flop that may go metastable
    logic [2:0]      filtered;
    wire logic [2:0] raw_in = {input_below_flash_threshold,
                               input_below_monitor_threshold,
                               thermal_sense_below_trip};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_sync
            logic [2:0] stage;
            logic       level;
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    stage <= 3'b000;
                    level <= 1'b0;
                end else begin
                    stage <= {stage[1:0], raw_in[g]};
                    if (stage[1] == stage[2])
                        level <= stage[2];
                end
            end
            assign filtered[g] = level;
        end
    endgenerate

    // =======================================================
    // event delay timers
    // the condition must hold for the whole delay; a dip resets the
    // count, which gives the flash monitor its deglitch, and each path
    // has its own copy of the same counter, flash on flash_cycles and the other two on slow_cycles
    wire logic [2:0]  qualify = {filtered[2] & flash_monitor_enable,
                                 filtered[1] & monitor_enable,
                                 filtered[0] & thermal_sense_mode};
    wire logic [31:0] limit [3];
    assign limit[0] = 32'(slow_cycles);
    assign limit[1] = 32'(slow_cycles);
    assign limit[2] = 32'(flash_cycles);

    wire logic [2:0] event_pulse;

    generate
        for (g = 0; g < 3; g++) begin : gen_delay
            // fires once per crossing; rearms when the condition clears
            logic [31:0] count;
            logic        done;
            wire logic   at_limit = count == limit[g] - 32'd1;
            assign event_pulse[g] = qualify[g] && !done && at_limit;
            always_ff @(posedge clk) begin
                if (!reset_n || !qualify[g]) begin
                    count <= 32'd0;
                    done  <= 1'b0;
                end else if (event_pulse[g]) begin
                    done <= 1'b1;
                end else if (!done) begin
                    count <= count + 32'd1;
                end
            end
        end
    endgenerate

    // =======================================================
    // flag pulses
    // the flags register lives outside; it sets its bit on these

    assign thermal_flag_pulse       = event_pulse[0];
    assign monitor_flag_pulse       = event_pulse[1];
    assign flash_monitor_flag_pulse = event_pulse[2];

    // =======================================================
    // capture of flash level
    // an idle led keeps its old nibble, so the register can still show a
    // code from an earlier event for an led that was not flashing at this one
    wire logic       capture_now    = |event_pulse;
    wire logic [3:0] next_led1_code = led1_active ?
        flash_current_code[3:0] :
        captured[led_flash_pkg::captured_led1_lsb +: 4];
    wire logic [3:0] next_led2_code = led2_active ?
        flash_current_code[7:4] :
        captured[led_flash_pkg::captured_led2_lsb +: 4];

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            captured <= led_flash_pkg::captured_flash_reset;
        end else if (capture_now) begin
            captured <= {next_led2_code, next_led1_code};
        end
    end
endmodule // led_flash_monitor_registers

// ===== verif/host_model.sv
// host model: register writes and address pointing
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    output logic            reg_write,
    output logic      [7:0] reg_address,
    output logic      [7:0] reg_write_data
);
    initial begin
        reg_write = 1'b0;
        reg_address = 8'h00;
        reg_write_data = 8'h00;
    end
    // strobe up for one edge only, so each write lands once
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        {reg_write, reg_address, reg_write_data} <= {1'b1, a, d};
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic point(input logic [7:0] a);
        @(posedge clk);
        reg_address <= a;
    endtask
endmodule // host_model

// ===== verif/led_flash_props.sv
// checker: register fields, map and event capture
`timescale 1ns/1ps
module led_flash_props #(
    parameter int slow_cycles  = 8,
    parameter int flash_cycles = 4
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       reg_write,
    input  wire logic       reg_address_valid,
    input  wire logic [7:0] reg_address,
    input  wire logic [7:0] reg_write_data,
    input  wire logic [7:0] reg_read_data,
    input  wire logic [7:0] flash_current_code,
    input  wire logic       thermal_sense_mode,
    input  wire logic       led1_active,
    input  wire logic       led2_active,
    input  wire logic       thermal_sense_below_trip,
    input  wire logic       input_below_flash_threshold,
    input  wire logic       input_below_monitor_threshold,
    input  wire logic       monitor_enable,
    input  wire logic       flash_monitor_enable,
    input  wire logic       thermal_flag_pulse,
    input  wire logic       monitor_flag_pulse,
    input  wire logic       flash_monitor_flag_pulse,
    input  wire logic [1:0] input_monitor_threshold,
    input  wire logic [1:0] input_flash_threshold,
    input  wire logic [2:0] torch_led1_code,
    input  wire logic [2:0] torch_led2_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire any_pulse = thermal_flag_pulse | monitor_flag_pulse
                   | flash_monitor_flag_pulse;
    wire at_cap = reg_address == 8'h81;
    sequence cfg_wr_s; reg_write && reg_address == 8'h80; endsequence
    sequence ev_s; any_pulse && led1_active && led2_active && at_cap
        ##1 at_cap; endsequence
    cfg_enable_a: assert property (cfg_wr_s |=>
        monitor_enable == $past(reg_write_data[0])
        && flash_monitor_enable == $past(reg_write_data[3]))
        else $error("monitor enable not stored");
    cfg_thresh_a: assert property (cfg_wr_s |=>
        input_monitor_threshold == $past(reg_write_data[2:1])
        && input_flash_threshold == $past(reg_write_data[5:4]))
        else $error("threshold select not stored");
    torch_fields_a: assert property (
        reg_write && reg_address == 8'ha0 |=>
        {torch_led2_code, torch_led1_code} == $past(reg_write_data[5:0]))
        else $error("torch fields not stored");
    reg_map_a: assert property (reg_address_valid ==
        (reg_address inside {8'h80, 8'h81, 8'ha0})
        && (reg_address_valid || reg_read_data == 8'h00))
        else $error("address decode wrong");
    cap_load_a: assert property (ev_s |->
        reg_read_data == $past(flash_current_code))
        else $error("capture not loaded with pulse");
    cap_hold_a: assert property (at_cap && !any_pulse |=>
        !at_cap || $stable(reg_read_data)) else $error("capture changed");
    thermal_delay_a: assert property (thermal_flag_pulse |->
        thermal_sense_mode && $past(thermal_sense_below_trip, slow_cycles)
        ##1 !thermal_flag_pulse) else $error("thermal pulse early");
    monitor_delay_a: assert property (monitor_flag_pulse |->
        monitor_enable && $past(input_below_monitor_threshold, slow_cycles))
        else $error("monitor pulse early");
    flash_delay_a: assert property (flash_monitor_flag_pulse |->
        flash_monitor_enable && $past(input_below_flash_threshold, flash_cycles))
        else $error("flash pulse early");
endmodule // led_flash_props
bind led_flash_monitor_registers led_flash_props #(
    .slow_cycles(slow_cycles), .flash_cycles(flash_cycles)) props_u (.*);

// ===== verif/tb_top.sv
// testbench: register access and event capture scenarios
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, reset_n = 1'b0, mode = 1'b0, l1 = 1'b0, l2 = 1'b0;
    logic [2:0] below = 3'b000;
    logic [7:0] code = 8'h00;
    logic wr, valid, m_en, f_en;
    logic [7:0] addr, wd, rd;
    logic [1:0] m_th, f_th;
    logic [2:0] t1, t2, p;
    int error_cnt = 0, checked = 0;
    initial forever #20 clk = ~clk;
    host_model host_u (.clk(clk), .reg_write(wr), .reg_address(addr),
        .reg_write_data(wd));
    // short counts keep the run brief; the bound checks scale with them, the capture bounds are fixed for 8 and 4
    led_flash_monitor_registers #(.slow_cycles(8), .flash_cycles(4)) dut_u (
        .clk(clk), .reset_n(reset_n), .reg_write(wr), .reg_address(addr),
        .reg_write_data(wd), .reg_read_data(rd), .reg_address_valid(valid),
        .thermal_sense_mode(mode), .flash_current_code(code),
        .led1_active(l1), .led2_active(l2),
        .thermal_sense_below_trip(below[0]),
        .input_below_monitor_threshold(below[1]),
        .input_below_flash_threshold(below[2]), .monitor_enable(m_en),
        .input_monitor_threshold(m_th), .flash_monitor_enable(f_en),
        .input_flash_threshold(f_th), .torch_led1_code(t1),
        .torch_led2_code(t2), .thermal_flag_pulse(p[0]),
        .monitor_flag_pulse(p[1]), .flash_monitor_flag_pulse(p[2]));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic look(input logic [7:0] a, input logic [7:0] exp);
        host_u.point(a);
        #1 check(rd, exp);
    endtask
    task automatic reset_values;
        look(8'h80, 8'h00);
        look(8'ha0, 8'h00);
        look(8'h55, 8'h00);
        check({7'h00, valid}, 8'h00);
        look(8'h81, 8'h00);
    endtask
    task automatic field_writes;
        host_u.write(8'h80, 8'hff);
        host_u.write(8'ha0, 8'hff);
        host_u.write(8'h81, 8'h5a);
        look(8'h80, 8'h3f);
        check({2'b00, t2, t1}, 8'h3f);
        look(8'h81, 8'h00);
        host_u.write(8'ha0, 8'h15);
        look(8'ha0, 8'h15);
        host_u.write(8'h80, 8'h39);
        look(8'h80, 8'h39);
        check({2'b00, f_th, m_th, f_en, m_en}, 8'h33);
    endtask
    // unused led keeps its old nibble, so led2 off shows a partial load
    task automatic capture(input int s, input logic [7:0] c, input logic b,
                           input logic [7:0] exp);
        int n;
        @(posedge clk);
        {code, l1, l2, mode, below[s]} <= {c, 1'b1, b, 1'b1, 1'b1};
        host_u.point(8'h81);
        for (n = 1; n < 40 && p[s] !== 1'b1; n++) @(negedge clk);
        if (n == 40) begin
            error_cnt++;
            test_done();
        end
        check({7'h00, n >= (s == 2 ? 4 : 8)}, 8'h01);
        check({7'h00, n <= (s == 2 ? 9 : 13)}, 8'h01);
        @(posedge clk);
        below[s] <= 1'b0;
        #1 check(rd, exp);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        reset_values();
        field_writes();
        capture(0, 8'hd2, 1'b1, 8'hd2);
        capture(1, 8'h7f, 1'b0, 8'hdf);
        capture(2, 8'hf0, 1'b1, 8'hf0);
        look(8'h80, 8'h39);
        look(8'h81, 8'hf0);
        test_done();
    end
endmodule // tb_top
